// ---- src/gpio_pkg.sv ----
// constants shared by the port logic
package gpio_pkg;
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 8;
    localparam int          PORT_A_W        = 3;
    localparam int          PORT_B_W        = 8;
    // register offsets
    localparam logic [3:0]  OFF_A_DIR       = 4'h0;
    localparam logic [3:0]  OFF_A_DATA      = 4'h1;
    localparam logic [3:0]  OFF_A_PIN       = 4'h2;
    localparam logic [3:0]  OFF_B_DIR       = 4'h4;
    localparam logic [3:0]  OFF_B_DATA      = 4'h5;
    localparam logic [3:0]  OFF_B_PIN       = 4'h6;
    localparam logic [3:0]  OFF_SER_CTRL    = 4'h8;
    // serial control field positions
    localparam int          SC_CKE_LOW      = 0;
    localparam int          SC_CKE_HIGH     = 1;
    localparam int          SC_SYNC         = 2;
    localparam int          SC_RX_EN        = 3;
    localparam int          SC_TX_EN        = 4;
    localparam int          SC_W            = 5;
    // reset values
    localparam logic [2:0]  A_RST           = 3'h0;
    localparam logic [7:0]  B_RST           = 8'h00;
    localparam logic [4:0]  SC_RST          = 5'h00;
    // value shown for undefined bits and unmapped reads
    localparam logic [7:0]  UNDEF_RD        = 8'h00;
    // pin numbers on port a
    localparam int          PIN_TXD         = 0;
    localparam int          PIN_RXD         = 1;
    localparam int          PIN_SCK         = 2;
    // pin 2 modes
    typedef enum logic [2:0] {
        SCK_GPIO = 3'h1,
        SCK_OUT  = 3'h2,
        SCK_IN   = 3'h4
    } sck_mode_t;
endpackage

// ---- src/pin_sync.sv ----
// two flop synchroniser for a pin bus
`timescale 1ns/100ps
`default_nettype none
module pin_sync
    import gpio_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } sync_state_t;

    sync_state_t state_ff;
    sync_state_t nxt_state;

    // first stage feeds only the second
    always_comb begin
        nxt_state      = state_ff;
        nxt_state.meta = pin_in;
        nxt_state.sync = state_ff.meta;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign pin_sync_out = state_ff.sync;
endmodule
`default_nettype wire

// ---- src/port_read_mux.sv ----
// per bit choice of output data or pin level
`timescale 1ns/100ps
`default_nettype none
module port_read_mux
    import gpio_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic [W-1:0] dir,
    input  wire logic [W-1:0] out_data,
    input  wire logic [W-1:0] pin_level,
    output logic      [W-1:0] read_val
);
    // direction 1 reads the latch, 0 reads the pin
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign read_val[i] = dir[i] ? out_data[i] : pin_level[i];
    end
endmodule
`default_nettype wire

// ---- src/port_a_b_gpio.sv ----
// gpio for the 3 bit port with serial pins and the 8 bit port
//
// Overview of operation
// - port a output data register, bits 2..0, reset 0, drives output pins
// - port a data and pin-read bits 7..3 read undefined, ignore writes
// - port a pin read gives data when direction 1, pin when 0
// - port a pin-read register is read only; writes change nothing
// - pin 2: clock in if cke high; clock out if sync or cke low
// - pin 1 is receive input when receive enable is set
// - pin 0 drives transmit data when transmit enable is set
// - port b direction write only, reset 0, 1 means output
// - port b direction reads return an undefined value
// - port b output data register, read/write, reset 0, drives pins
// - port a direction write only, bits 2..0, reset 0
// - port b pin read gives data when direction 1, pin when 0
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module port_a_b_gpio
    import gpio_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                rstn,
    input  wire logic [ADDR_W-1:0]   addr,
    input  wire logic [DATA_W-1:0]   wdata,
    input  wire logic                wr_en,
    input  wire logic                rd_en,
    output logic      [DATA_W-1:0]   rdata,
    input  wire logic [PORT_A_W-1:0] port_a_in,
    output logic      [PORT_A_W-1:0] port_a_out,
    output logic      [PORT_A_W-1:0] port_a_oe_n,
    input  wire logic [PORT_B_W-1:0] port_b_in,
    output logic      [PORT_B_W-1:0] port_b_out,
    output logic      [PORT_B_W-1:0] port_b_oe_n,
    input  wire logic                serial_transmit_data,
    input  wire logic                serial_clock_out,
    output logic                     serial_receive_data,
    output logic                     serial_clock_in
);
    //------------------------------------------------------------------
    // state
    //------------------------------------------------------------------
    typedef struct packed {
        logic [PORT_A_W-1:0] port_a_direction;
        logic [PORT_A_W-1:0] port_a_output_data;
        logic [PORT_B_W-1:0] port_b_direction;
        logic [PORT_B_W-1:0] port_b_output_data;
        logic [SC_W-1:0]     serial_ctrl;
        logic [DATA_W-1:0]   rdata;
        logic [PORT_A_W-1:0] a_out;
        logic [PORT_A_W-1:0] a_oe_n;
        logic [PORT_B_W-1:0] b_out;
        logic [PORT_B_W-1:0] b_oe_n;
        logic                rx_data;
        logic                sck_in;
    } gpio_state_t;

    gpio_state_t         state_ff;
    gpio_state_t         nxt_state;
    logic [PORT_A_W-1:0] a_sync;
    logic [PORT_B_W-1:0] b_sync;
    logic [PORT_A_W-1:0] a_read;
    logic [PORT_B_W-1:0] b_read;
    sck_mode_t           sck_mode;

    //------------------------------------------------------------------
    // pin synchronisers and read muxes
    //------------------------------------------------------------------
    // two flop pin sampling
    pin_sync #(.W(PORT_A_W)) u_sync_a (
        .sys_clk      (sys_clk),
        .rstn         (rstn),
        .pin_in       (port_a_in),
        .pin_sync_out (a_sync)
    );

    pin_sync #(.W(PORT_B_W)) u_sync_b (
        .sys_clk      (sys_clk),
        .rstn         (rstn),
        .pin_in       (port_b_in),
        .pin_sync_out (b_sync)
    );

    port_read_mux #(.W(PORT_A_W)) u_mux_a (
        .dir       (state_ff.port_a_direction),
        .out_data  (state_ff.port_a_output_data),
        .pin_level (a_sync),
        .read_val  (a_read)
    );

    port_read_mux #(.W(PORT_B_W)) u_mux_b (
        .dir       (state_ff.port_b_direction),
        .out_data  (state_ff.port_b_output_data),
        .pin_level (b_sync),
        .read_val  (b_read)
    );

    //------------------------------------------------------------------
    // pin 2 mode decode
    //------------------------------------------------------------------
    function automatic sck_mode_t decode_sck(input logic [SC_W-1:0] sc);
        sck_mode_t m;
        m = SCK_GPIO;
        if (sc[SC_CKE_HIGH]) begin
            m = SCK_IN;
        end else if (sc[SC_SYNC] || sc[SC_CKE_LOW]) begin
            m = SCK_OUT;
        end
        return m;
    endfunction

    assign sck_mode = decode_sck(state_ff.serial_ctrl);

    //------------------------------------------------------------------
    // next state
    //------------------------------------------------------------------
    always_comb begin
        nxt_state       = state_ff;
        nxt_state.rdata = UNDEF_RD;
        if (wr_en) begin
            case (addr)
                OFF_A_DIR: begin
                    nxt_state.port_a_direction = wdata[PORT_A_W-1:0];
                end
                OFF_A_DATA: begin
                    nxt_state.port_a_output_data = wdata[PORT_A_W-1:0];
                end
                OFF_B_DIR: begin
                    nxt_state.port_b_direction = wdata[PORT_B_W-1:0];
                end
                OFF_B_DATA: begin
                    nxt_state.port_b_output_data = wdata[PORT_B_W-1:0];
                end
                OFF_SER_CTRL: begin
                    nxt_state.serial_ctrl = wdata[SC_W-1:0];
                end
                default: begin
                    nxt_state.serial_ctrl = state_ff.serial_ctrl;
                end
            endcase
        end
        // direction reads give the undefined value
        if (rd_en) begin
            case (addr)
                // high bits read as the undefined value
                OFF_A_DATA: begin
                    nxt_state.rdata = {UNDEF_RD[DATA_W-1:PORT_A_W],
                                       state_ff.port_a_output_data};
                end
                OFF_A_PIN: begin
                    nxt_state.rdata = {UNDEF_RD[DATA_W-1:PORT_A_W], a_read};
                end
                OFF_B_DATA: begin
                    nxt_state.rdata = state_ff.port_b_output_data;
                end
                OFF_B_PIN: begin
                    nxt_state.rdata = b_read;
                end
                OFF_SER_CTRL: begin
                    nxt_state.rdata = {{(DATA_W-SC_W){1'b0}}, state_ff.serial_ctrl};
                end
                default: begin
                    nxt_state.rdata = UNDEF_RD;
                end
            endcase
        end
        // general purpose pins follow the registers
        nxt_state.a_out  = state_ff.port_a_output_data;
        nxt_state.a_oe_n = ~state_ff.port_a_direction;
        nxt_state.b_out  = state_ff.port_b_output_data;
        nxt_state.b_oe_n = ~state_ff.port_b_direction;
        if (state_ff.serial_ctrl[SC_TX_EN]) begin
            nxt_state.a_out[PIN_TXD]  = serial_transmit_data;
            nxt_state.a_oe_n[PIN_TXD] = 1'b0;
        end
        if (state_ff.serial_ctrl[SC_RX_EN]) begin
            nxt_state.a_oe_n[PIN_RXD] = 1'b1;
        end
        nxt_state.rx_data = a_sync[PIN_RXD];
        nxt_state.sck_in  = a_sync[PIN_SCK];
        case (sck_mode)
            SCK_OUT: begin
                nxt_state.a_out[PIN_SCK]  = serial_clock_out;
                nxt_state.a_oe_n[PIN_SCK] = 1'b0;
            end
            SCK_IN: begin
                nxt_state.a_oe_n[PIN_SCK] = 1'b1;
            end
            default: begin
                nxt_state.a_oe_n[PIN_SCK] = ~state_ff.port_a_direction[PIN_SCK];
            end
        endcase
    end

    //------------------------------------------------------------------
    // state register
    //------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff                    <= '0;
            state_ff.port_a_direction   <= A_RST;
            state_ff.port_a_output_data <= A_RST;
            state_ff.port_b_direction   <= B_RST;
            state_ff.port_b_output_data <= B_RST;
            state_ff.serial_ctrl        <= SC_RST;
            state_ff.a_oe_n             <= '1;
            state_ff.b_oe_n             <= '1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rdata               = state_ff.rdata;
    assign port_a_out          = state_ff.a_out;
    assign port_a_oe_n         = state_ff.a_oe_n;
    assign port_b_out          = state_ff.b_out;
    assign port_b_oe_n         = state_ff.b_oe_n;
    assign serial_receive_data = state_ff.rx_data;
    assign serial_clock_in     = state_ff.sck_in;

    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------
    // written low bits land in the data register at the next edge
    property p_a_data_write;
        @(posedge sys_clk) disable iff (!rstn)
        (wr_en && addr == OFF_A_DATA) |=>
            state_ff.port_a_output_data == $past(wdata[PORT_A_W-1:0]);
    endproperty
    a_a_data_write: assert property (p_a_data_write) else $error("port a data write lost");

    property p_a_hi_undef;
        @(posedge sys_clk) disable iff (!rstn)
        $past(rd_en) && ($past(addr) == OFF_A_DATA || $past(addr) == OFF_A_PIN)
            |-> rdata[DATA_W-1:PORT_A_W] == UNDEF_RD[DATA_W-1:PORT_A_W];
    endproperty
    a_a_hi_undef: assert property (p_a_hi_undef) else $error("port a high bits wrong");

    property p_a_pin_read;
        @(posedge sys_clk) disable iff (!rstn)
        (rd_en && addr == OFF_A_PIN) |=> rdata[PORT_A_W-1:0] ==
            (($past(state_ff.port_a_direction) & $past(state_ff.port_a_output_data))
            | (~$past(state_ff.port_a_direction) & $past(a_sync)));
    endproperty
    a_a_pin_read: assert property (p_a_pin_read) else $error("port a pin read wrong");

    property p_pin_ro;
        @(posedge sys_clk) disable iff (!rstn)
        (wr_en && (addr == OFF_A_PIN || addr == OFF_B_PIN)) |=>
            $stable(state_ff.port_a_output_data) && $stable(state_ff.port_b_output_data)
            && $stable(state_ff.port_a_direction) && $stable(state_ff.port_b_direction);
    endproperty
    a_pin_ro: assert property (p_pin_ro) else $error("pin read write changed state");

    property p_sck_in;
        @(posedge sys_clk) disable iff (!rstn)
        state_ff.serial_ctrl[SC_CKE_HIGH] |=> port_a_oe_n[PIN_SCK];
    endproperty
    a_sck_in: assert property (p_sck_in) else $error("clock pin driven in input mode");

    property p_sck_out;
        @(posedge sys_clk) disable iff (!rstn)
        (!state_ff.serial_ctrl[SC_CKE_HIGH]
            && (state_ff.serial_ctrl[SC_SYNC] || state_ff.serial_ctrl[SC_CKE_LOW]))
            |=> !port_a_oe_n[PIN_SCK] && port_a_out[PIN_SCK] == $past(serial_clock_out);
    endproperty
    a_sck_out: assert property (p_sck_out) else $error("clock pin not driven");

    property p_rx_in;
        @(posedge sys_clk) disable iff (!rstn)
        state_ff.serial_ctrl[SC_RX_EN] |=> port_a_oe_n[PIN_RXD];
    endproperty
    a_rx_in: assert property (p_rx_in) else $error("receive pin driven");

    property p_tx_out;
        @(posedge sys_clk) disable iff (!rstn)
        state_ff.serial_ctrl[SC_TX_EN] |=>
            !port_a_oe_n[PIN_TXD] && port_a_out[PIN_TXD] == $past(serial_transmit_data);
    endproperty
    a_tx_out: assert property (p_tx_out) else $error("transmit pin wrong");

    property p_b_dir;
        @(posedge sys_clk) disable iff (!rstn)
        (wr_en && addr == OFF_B_DIR) |=> ##1 port_b_oe_n == ~$past(wdata, 2);
    endproperty
    a_b_dir: assert property (p_b_dir) else $error("port b direction not applied");

    property p_b_dir_rd;
        @(posedge sys_clk) disable iff (!rstn)
        (rd_en && addr == OFF_B_DIR) |=> rdata == UNDEF_RD;
    endproperty
    a_b_dir_rd: assert property (p_b_dir_rd) else $error("direction readback leaked");

    property p_b_data;
        @(posedge sys_clk) disable iff (!rstn)
        (wr_en && addr == OFF_B_DATA) ##1 (rd_en && addr == OFF_B_DATA)
            |=> rdata == $past(wdata, 2);
    endproperty
    a_b_data: assert property (p_b_data) else $error("port b data readback wrong");

    property p_a_dir;
        @(posedge sys_clk) disable iff (!rstn)
        (wr_en && addr == OFF_A_DIR && !state_ff.serial_ctrl[SC_TX_EN])
            |=> ##1 port_a_oe_n[PIN_TXD] == !$past(wdata[PIN_TXD], 2);
    endproperty
    a_a_dir: assert property (p_a_dir) else $error("port a direction not applied");

    property p_b_pin_read;
        @(posedge sys_clk) disable iff (!rstn)
        (rd_en && addr == OFF_B_PIN) |=> rdata ==
            (($past(state_ff.port_b_direction) & $past(state_ff.port_b_output_data))
            | (~$past(state_ff.port_b_direction) & $past(b_sync)));
    endproperty
    a_b_pin_read: assert property (p_b_pin_read) else $error("port b pin read wrong");

    property p_sync_delay;
        @(posedge sys_clk) disable iff (!rstn)
        rstn |-> ##2 b_sync == $past(port_b_in, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("pin sync depth wrong");

    c_tx_mode:  cover property (@(posedge sys_clk) state_ff.serial_ctrl[SC_TX_EN]);
    c_sck_out:  cover property (@(posedge sys_clk) sck_mode == SCK_OUT);
    c_b_read:   cover property (@(posedge sys_clk) rd_en && addr == OFF_B_PIN);
    c_b_output: cover property (@(posedge sys_clk) state_ff.port_b_direction == '1);
    c_rx_mode:  cover property (@(posedge sys_clk) state_ff.serial_ctrl[SC_RX_EN]);
endmodule
`default_nettype wire

// ---- testbench/pin_partner.sv ----
// model of the outside pins and the serial channel around the gpio block
`timescale 1ns/100ps
`default_nettype none
module pin_partner
    import gpio_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                rstn,
    input  wire logic [PORT_A_W-1:0] ext_a,
    input  wire logic [PORT_B_W-1:0] ext_b,
    input  wire logic                sck_run,
    input  wire logic [PORT_A_W-1:0] port_a_out,
    input  wire logic [PORT_A_W-1:0] port_a_oe_n,
    input  wire logic [PORT_B_W-1:0] port_b_out,
    input  wire logic [PORT_B_W-1:0] port_b_oe_n,
    output logic      [PORT_A_W-1:0] port_a_in,
    output logic      [PORT_B_W-1:0] port_b_in,
    output logic                     serial_clock_out
);
    // ------------------------------------------------------------
    // wire levels
    // ------------------------------------------------------------
    // device drive wins, otherwise the outside level shows
    assign port_a_in = (port_a_out & ~port_a_oe_n) | (ext_a & port_a_oe_n);
    assign port_b_in = (port_b_out & ~port_b_oe_n) | (ext_b & port_b_oe_n);

    // ------------------------------------------------------------
    // serial channel clock
    // ------------------------------------------------------------
    // toggles only within a frame, stands still between frames
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            serial_clock_out <= 1'b0;
        end else if (sck_run) begin
            serial_clock_out <= ~serial_clock_out;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/port_a_b_gpio_tb.sv ----
// self-checking bench for the two-port gpio block
`timescale 1ns/100ps
`default_nettype none
module port_a_b_gpio_tb
    import gpio_pkg::*;
;
    logic                sys_clk = 1'b0;
    logic                rstn    = 1'b0;
    logic [ADDR_W-1:0]   addr    = '0;
    logic [DATA_W-1:0]   wdata   = '0;
    logic                wr_en   = 1'b0;
    logic                rd_en   = 1'b0;
    logic [DATA_W-1:0]   rdata;
    logic [PORT_A_W-1:0] port_a_in, port_a_out, port_a_oe_n;
    logic [PORT_B_W-1:0] port_b_in, port_b_out, port_b_oe_n;
    logic                serial_transmit_data = 1'b0;
    logic                serial_clock_out, serial_receive_data, serial_clock_in;
    logic [PORT_A_W-1:0] ext_a   = '0;
    logic [PORT_B_W-1:0] ext_b   = '0;
    logic                sck_run = 1'b0;
    int                  fails   = 0;
    int                  tests_run = 0;
    logic [7:0]          rv;
    logic [7:0]          sc_tab [5] = '{8'h00, 8'h01, 8'h04, 8'h02, 8'h06};
    logic                oe_tab [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

    always #5 sys_clk = ~sys_clk;

    port_a_b_gpio i_port_a_b_gpio (.sys_clk(sys_clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .port_a_in(port_a_in), .port_a_out(port_a_out), .port_a_oe_n(port_a_oe_n),
        .port_b_in(port_b_in), .port_b_out(port_b_out), .port_b_oe_n(port_b_oe_n),
        .serial_transmit_data(serial_transmit_data), .serial_clock_out(serial_clock_out),
        .serial_receive_data(serial_receive_data), .serial_clock_in(serial_clock_in));

    pin_partner i_pin_partner (.sys_clk(sys_clk), .rstn(rstn), .ext_a(ext_a),
        .ext_b(ext_b), .sck_run(sck_run), .port_a_out(port_a_out),
        .port_a_oe_n(port_a_oe_n), .port_b_out(port_b_out), .port_b_oe_n(port_b_oe_n),
        .port_a_in(port_a_in), .port_b_in(port_b_in), .serial_clock_out(serial_clock_out));

    // ------------------------------------------------------------
    // compare, bus and closing tasks
    // ------------------------------------------------------------
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("BAD reg t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("BAD pin t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic give_verdict;
        $display("counts: run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset;
        chk_pin(8'(port_a_oe_n), 8'h07); // a inputs
        chk_pin(port_b_oe_n, 8'hFF); // b inputs
        reg_rd(OFF_A_DATA, rv); chk_reg(rv, 8'h00); // a data zero
        reg_rd(OFF_B_DATA, rv); chk_reg(rv, 8'h00); // b data zero
        $display("test reset done");
    endtask

    task automatic test_port_b;
        reg_wr(OFF_B_DIR, 8'h0F);
        reg_wr(OFF_B_DATA, 8'hA5);
        ext_b <= 8'h3C;
        settle(4);
        chk_pin(port_b_oe_n, 8'hF0); // low nibble out
        chk_pin(port_b_out & 8'h0F, 8'h05); // data on pins
        reg_rd(OFF_B_PIN, rv); chk_reg(rv, 8'h35); // mixed read
        reg_rd(OFF_B_DIR, rv); chk_reg(rv, UNDEF_RD); // dir unreadable
        reg_wr(OFF_B_PIN, 8'hFF);
        reg_rd(OFF_B_DATA, rv); chk_reg(rv, 8'hA5); // data readback
        // write then read with no gap
        @(posedge sys_clk);
        wdata <= 8'h3C;
        wr_en <= 1'b1;
        addr  <= OFF_B_DATA;
        @(posedge sys_clk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        chk_reg(rdata, 8'h3C); // next edge update
        $display("test port b done");
    endtask

    task automatic test_port_a;
        reg_wr(OFF_SER_CTRL, 8'h00);
        reg_wr(OFF_A_DIR, 8'hFD);
        reg_wr(OFF_A_DATA, 8'hFF);
        ext_a <= 3'b000;
        settle(4);
        chk_pin(8'(port_a_oe_n), 8'h02); // dir bits
        chk_pin(8'(port_a_out & 3'b101), 8'h05); // data on pins
        reg_rd(OFF_A_DATA, rv); chk_reg(rv, 8'h07); // upper bits
        reg_wr(OFF_A_PIN, 8'h00);
        reg_rd(OFF_A_DATA, rv); chk_reg(rv, 8'h07); // pin write ignored
        reg_rd(OFF_A_PIN, rv); chk_reg(rv, 8'h05); // pin low
        ext_a <= 3'b010;
        settle(4);
        reg_rd(OFF_A_PIN, rv); chk_reg(rv, 8'h07); // pin high
        reg_rd(OFF_A_DIR, rv); chk_reg(rv, UNDEF_RD); // dir unreadable
        reg_rd(4'hF, rv); chk_reg(rv, UNDEF_RD); // unmapped read
        $display("test port a done");
    endtask

    task automatic test_serial;
        reg_wr(OFF_A_DIR, 8'h00);
        reg_wr(OFF_SER_CTRL, 8'h10);
        for (int t = 0; t < 2; t++) begin
            @(posedge sys_clk);
            serial_transmit_data <= t[0];
            settle(3);
            chk_pin(8'(port_a_out[PIN_TXD]), 8'(t[0])); // tx drive
            chk_pin(8'(port_a_oe_n[PIN_TXD]), 8'h00); // tx enabled
        end
        reg_wr(OFF_A_DIR, 8'h07);
        reg_wr(OFF_SER_CTRL, 8'h08);
        ext_a <= 3'b010;
        settle(5);
        chk_pin(8'(port_a_oe_n[PIN_RXD]), 8'h01); // rx undriven
        chk_pin(8'(serial_receive_data), 8'h01); // rx high
        ext_a <= 3'b000;
        settle(5);
        chk_pin(8'(serial_receive_data), 8'h00); // rx low
        reg_wr(OFF_A_DIR, 8'h04);
        for (int i = 0; i < 5; i++) begin
            reg_wr(OFF_SER_CTRL, sc_tab[i]);
            sck_run <= 1'b1;
            settle(3);
            sck_run <= 1'b0;
            ext_a   <= 3'b100;
            settle(4);
            chk_pin(8'(port_a_oe_n[PIN_SCK]), 8'(oe_tab[i])); // clock pin mode
            if (oe_tab[i]) begin
                chk_pin(8'(serial_clock_in), 8'h01); // clock input
            end else if (i == 0) begin
                chk_pin(8'(port_a_out[PIN_SCK]), 8'h01); // gpio output
            end else begin
                chk_pin(8'(port_a_out[PIN_SCK]), 8'(serial_clock_out)); // clock out
            end
        end
        $display("test serial done");
    endtask

    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        test_reset();
        test_port_b();
        test_port_a();
        test_serial();
        // second reset in mid-run, written registers must fall back
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        test_reset();
        give_verdict();
    end

    initial begin
        #200000;
        fails++;
        $display("BAD t=%0t run limit hit", $time);
        give_verdict();
    end
endmodule
`default_nettype wire
